// [timer_pkg.sv]
// Shared constants and carrier types for the enhanced timer/PWM unit
package timer_pkg;

   // ********************
   // Register map (word index on the register port)
   // ********************
   localparam int          ADDR_W             = 4;
   localparam logic [3:0]  OFF_CONTROL        = 4'h0; // Control/status
   localparam logic [3:0]  OFF_COUNT          = 4'h1; // Count value
   localparam logic [3:0]  OFF_RELOAD         = 4'h2; // Reload/capture
   localparam logic [3:0]  OFF_COMPARE        = 4'h3; // Compare value
   localparam logic [3:0]  OFF_INT_STATUS     = 4'h4; // Sticky events, RO
   localparam logic [3:0]  OFF_INT_CLEAR      = 4'h5; // Write one to clear
   localparam logic [3:0]  OFF_INT_ENABLE     = 4'h6; // Event enables

   // ********************
   // Control/status field positions
   // ********************
   localparam int BIT_CAPTURE_RELOAD   = 0;
   localparam int BIT_INTERRUPT_ENABLE = 1;
   localparam int BIT_RUN              = 2;
   localparam int BIT_EXT_PIN_ENABLE   = 3;
   localparam int BIT_UPDOWN_ENABLE    = 4;
   localparam int BIT_WAVE_OUT_ENABLE  = 5;
   localparam int BIT_EXTERNAL_FLAG    = 6;
   localparam int BIT_OVERFLOW_FLAG    = 7;
   localparam int BIT_PRESCALE_LO      = 8;
   localparam int BIT_PWM_CLEAR        = 11;
   localparam int BIT_PWM_SET          = 12;
   localparam int BIT_COUNTER_SELECT   = 15;

   // Bits 14 and 13 never store and read as zero
   localparam logic [15:0] CONTROL_WR_MASK    = 16'h9fff;
   localparam logic [15:0] CONTROL_RESET      = 16'h0000;
   localparam logic [15:0] VALUE_RESET        = 16'h0000;

   // ********************
   // Interrupt status bit positions
   // ********************
   localparam int          NUM_EVENTS         = 3;
   localparam int          EVT_OVERFLOW       = 0;
   localparam int          EVT_EXTERNAL       = 1;
   localparam int          EVT_COMPARE        = 2;

   // Prescaler counter width (largest divisor is 1024)
   localparam int          PRESCALE_W         = 10;

   // Register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
      logic              wr;
      logic              rd;
   } reg_req_s;

   // Count direction, one-hot
   typedef enum logic [1:0] {
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } dir_e;

endpackage : timer_pkg

// [timer_prescaler.sv]
// Prescaler producing the one-cycle count enable for the timer
`timescale 1ns/1ps
module timer_prescaler
   import timer_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       enable,     // Run bit; holds state when low
   input  wire logic [2:0] select,     // Divisor selection code
   output logic            tick        // One-cycle count enable
);

   // ************************************************************
   // Divisor decode
   // ************************************************************

   // Terminal count is divisor minus one; unused codes divide by 1
   function automatic logic [PRESCALE_W-1:0] last_count(
      input logic [2:0] sel);
      case (sel)
         3'h1:    last_count = 10'h003;  // By 4
         3'h2:    last_count = 10'h00f;  // By 16
         3'h3:    last_count = 10'h03f;  // By 64
         3'h4:    last_count = 10'h0ff;  // By 256
         3'h5:    last_count = 10'h3ff;  // By 1024
         default: last_count = 10'h000;  // By 1
      endcase
   endfunction : last_count

   logic [PRESCALE_W-1:0] div_cnt_ff;   // Running divider count
   wire  logic            at_last;      // Divider at terminal count

   // Comparing with >= keeps a shrinking divisor from wrapping long
   assign at_last = (div_cnt_ff >= last_count(select)); // see RULE3
   assign tick    = enable & at_last;

   // ************************************************************
   // Divider counter
   // ************************************************************

   // Halted divider keeps its phase so a restart resumes cleanly
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_ff <= '0;
      end else if (enable) begin
         div_cnt_ff <= at_last ? '0 : div_cnt_ff + 10'h001;
      end
   end

endmodule : timer_prescaler

// [timer_pwm_unit.sv]
// Enhanced 16-bit timer/counter with PWM, capture and reload
//
// What this block does
// RULE1 - Reload without PWM toggles external flag, silently
// RULE2 - Overflow flag sets on each wrap; software clears
// RULE3 - Prescaler codes divide by 1,4,16,64,256,1024,1,1
// RULE4 - Clear-mode PWM: low at compare, high at reload
// RULE5 - Set-mode PWM: high at compare, low at reload
// RULE6 - Both PWM bits: pin toggles at compare
// RULE7 - Counter select picks prescaled clock or input transitions
// RULE8 - Software loads reload, then writes 0x0024 square wave
// RULE9 - PWM 0x0804: high below compare, low on match
// RULE10 - PWM counter runs to reload, then returns zero
// RULE11 - Reload on wrap, or capture count on falling pin
// RULE12 - Run bit counts; clear halts with state kept
// RULE13 - Up/down: pin picks direction; PWM counts triangle
// RULE14 - Waveform enable with counter select clear drives output pin, else released
// RULE15 - Control bits 14 and 13 read zero, ignore writes
`timescale 1ns/1ps
module timer_pwm_unit
   import timer_pkg::*;
#(
   parameter int WIDTH = 16              // Counter width
)
(
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire reg_req_s         reg_req,           // Register access
   output logic [15:0]           read_data,         // Valid next cycle
   input  wire logic             count_input_pin,   // External count
   input  wire logic             pwm_capture_pin_i, // Pin level seen
   output logic                  pwm_capture_pin_o, // Pin drive value
   output logic                  pwm_capture_pin_oe_n, // Low = driving
   output logic                  waveform_output_pin,  // Square wave
   output logic                  waveform_output_oe_n, // Low = driving
   output logic                  irq                // Level interrupt
);

   localparam logic [WIDTH-1:0] ALL_ONES = '1;

   // ********************
   // Register address decode
   // ********************

   // Word match used for both write and read decode
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   wire logic wr_control  = reg_req.wr & reg_hit(reg_req.addr, OFF_CONTROL);
   wire logic wr_count    = reg_req.wr & reg_hit(reg_req.addr, OFF_COUNT);
   wire logic wr_reload   = reg_req.wr & reg_hit(reg_req.addr, OFF_RELOAD);
   wire logic wr_compare  = reg_req.wr & reg_hit(reg_req.addr, OFF_COMPARE);
   wire logic wr_int_clr  = reg_req.wr & reg_hit(reg_req.addr, OFF_INT_CLEAR);
   wire logic wr_int_en   = reg_req.wr & reg_hit(reg_req.addr, OFF_INT_ENABLE);

   // ********************
   // State
   // ********************
   logic [15:0]           control_ff;     // Configuration bits
   logic                  overflow_flag_ff; // Sticky wrap flag
   logic                  external_flag_ff; // Edge / toggle flag
   logic [WIDTH-1:0]      count_value_ff;   // Current count
   logic [WIDTH-1:0]      reload_capture_value_ff; // Reload/capture
   logic [WIDTH-1:0]      compare_value_ff; // Compare value
   dir_e                  dir_ff;           // Triangle direction
   logic                  count_in_prev_ff; // Count pin last level
   logic                  capture_prev_ff;  // Capture pin last level
   logic                  pwm_level_ff;     // PWM pin level
   logic                  wave_level_ff;    // Square-wave level
   logic [NUM_EVENTS-1:0] int_status_ff;    // Sticky events
   logic [NUM_EVENTS-1:0] int_enable_ff;    // Event enables
   logic [15:0]           read_data_ff;     // Registered read answer
   logic                  irq_ff;           // Registered interrupt

   // ********************
   // Control field views
   // ********************
   wire logic capture_mode = control_ff[BIT_CAPTURE_RELOAD];
   wire logic int_enable   = control_ff[BIT_INTERRUPT_ENABLE];
   wire logic run_bit      = control_ff[BIT_RUN];
   wire logic ext_pin_en   = control_ff[BIT_EXT_PIN_ENABLE];
   wire logic updown_en    = control_ff[BIT_UPDOWN_ENABLE];
   wire logic wave_out_en  = control_ff[BIT_WAVE_OUT_ENABLE];
   wire logic pwm_clear    = control_ff[BIT_PWM_CLEAR];
   wire logic pwm_set      = control_ff[BIT_PWM_SET];
   wire logic counter_sel  = control_ff[BIT_COUNTER_SELECT];
   wire logic pwm_mode     = pwm_clear | pwm_set;
   wire logic [2:0] prescale_sel =
      control_ff[BIT_PRESCALE_LO+2:BIT_PRESCALE_LO];

   // ********************
   // Count enable source
   // ********************
   logic      prescale_tick;  // Prescaled system clock pulse

   timer_prescaler u_prescaler (
      .clock   (clock),
      .reset_n (reset_n),
      .enable  (run_bit),
      .select  (prescale_sel),
      .tick    (prescale_tick)
   );

   // Any transition of the count pin is one count
   wire logic count_edge = count_input_pin ^ count_in_prev_ff;
   wire logic step = run_bit &
      (counter_sel ? count_edge : prescale_tick); // see RULE7 RULE12

   // Falling edge on the capture pin, only while the pin is enabled
   wire logic pin_fall = ext_pin_en & capture_prev_ff &
                         ~pwm_capture_pin_i;

   // ********************
   // Direction and wrap points
   // ********************

   // PWM with up/down runs a triangle; up/down without PWM lets the pin steer
   wire logic triangle = pwm_mode & updown_en;
   wire logic count_up = ~updown_en ? 1'b1 :
      (triangle ? (dir_ff == DIR_UP) : pwm_capture_pin_i); // see RULE13
   wire logic at_reload = (count_value_ff == reload_capture_value_ff);
   wire logic at_zero   = (count_value_ff == '0);
   wire logic at_max    = (count_value_ff == ALL_ONES);
   // Capture mode frees the reload register, so wrap at full scale
   wire logic top_hit   = step & count_up &
      (capture_mode ? at_max : at_reload);
   wire logic bottom_hit = step & ~count_up & at_zero;
   wire logic overflow  = (top_hit & ~triangle) | bottom_hit;

   // ********************
   // Next count value
   // ********************
   logic [WIDTH-1:0] nxt_count;   // Count after this cycle
   dir_e             nxt_dir;     // Direction after this cycle

   always_comb begin
      nxt_count = count_value_ff;
      nxt_dir   = dir_ff;
      if (step) begin
         if (triangle && top_hit) begin
            nxt_dir   = DIR_DOWN;                    // see RULE13
            nxt_count = count_value_ff - 1'b1;
         end else if (triangle && bottom_hit) begin
            nxt_dir   = DIR_UP;                      // see RULE13
            nxt_count = count_value_ff + 1'b1;
         end else if (top_hit) begin
            nxt_count = '0;                          // see RULE10 RULE11
         end else if (bottom_hit) begin
            // Down wrap reloads, or rolls to full scale when capturing
            nxt_count = capture_mode ? ALL_ONES :
                        reload_capture_value_ff;     // see RULE11
         end else if (count_up) begin
            nxt_count = count_value_ff + 1'b1;
         end else begin
            nxt_count = count_value_ff - 1'b1;
         end
      end
      // External reload restarts the period from the pin
      if (pin_fall && !capture_mode && !pwm_mode) begin
         nxt_count = count_up ? '0 : reload_capture_value_ff;
      end
      // Software write has the last word on the count
      if (wr_count) begin
         nxt_count = reg_req.wdata[WIDTH-1:0];
      end
      if (!triangle) begin
         nxt_dir = DIR_UP;
      end
   end

   // ********************
   // Compare and pin events
   // ********************

   // Match is taken on the value the count steps into
   wire logic cmp_hit = step & (nxt_count == compare_value_ff);
   wire logic capture_now = pin_fall & capture_mode & ~pwm_mode;

   // Pin event that raises the external flag and its interrupt
   wire logic ext_event = pin_fall &
      (pwm_mode | capture_mode | count_up);
   // Reload mode without PWM toggles the flag and raises nothing
   wire logic ext_toggle = overflow & ~capture_mode & ~pwm_mode;

   logic nxt_pwm_level;   // PWM pin level after this cycle

   always_comb begin
      nxt_pwm_level = pwm_level_ff;
      if (pwm_clear && pwm_set) begin
         if (cmp_hit) nxt_pwm_level = ~pwm_level_ff;   // see RULE6
      end else if (pwm_clear) begin
         // Low once the count meets compare, high at reload
         if (cmp_hit) nxt_pwm_level = 1'b0;           // see RULE4 RULE9
         else if (top_hit) nxt_pwm_level = 1'b1;      // see RULE4
      end else if (pwm_set) begin
         if (cmp_hit) nxt_pwm_level = 1'b1;           // see RULE5
         else if (top_hit) nxt_pwm_level = 1'b0;      // see RULE5
      end
   end

   // ********************
   // Flag next values
   // ********************

   // Hardware set wins over a software clear in the same cycle
   wire logic nxt_overflow_flag = overflow |
      (wr_control ? reg_req.wdata[BIT_OVERFLOW_FLAG]
                  : overflow_flag_ff);               // see RULE2
   wire logic ext_flag_base = wr_control ?
      reg_req.wdata[BIT_EXTERNAL_FLAG] : external_flag_ff;
   wire logic nxt_external_flag = ext_event |
      (ext_flag_base ^ ext_toggle);                  // see RULE1

   wire logic [NUM_EVENTS-1:0] event_vec = {cmp_hit, ext_event, overflow};

   // ********************
   // Control, flags and value registers
   // ********************

   // Flags live outside control_ff so hardware owns their set side
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         control_ff <= CONTROL_RESET;
      end else if (wr_control) begin
         control_ff <= reg_req.wdata & CONTROL_WR_MASK; // see RULE15
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         overflow_flag_ff <= 1'b0;
         external_flag_ff <= 1'b0;
      end else begin
         overflow_flag_ff <= nxt_overflow_flag;
         external_flag_ff <= nxt_external_flag;
      end
   end

   // Count keeps its state whenever step is low, unless a count write or a pin reload loads it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_value_ff <= VALUE_RESET[WIDTH-1:0];
         dir_ff         <= DIR_UP;
      end else begin
         count_value_ff <= nxt_count;                // see RULE12
         dir_ff         <= nxt_dir;
      end
   end

   // Capture overrides a software write in the same cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reload_capture_value_ff <= VALUE_RESET[WIDTH-1:0];
      end else if (capture_now) begin
         reload_capture_value_ff <= count_value_ff;  // see RULE11
      end else if (wr_reload) begin
         reload_capture_value_ff <= reg_req.wdata[WIDTH-1:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         compare_value_ff <= VALUE_RESET[WIDTH-1:0];
      end else if (wr_compare) begin
         compare_value_ff <= reg_req.wdata[WIDTH-1:0];
      end
   end

   // ********************
   // Pin history and output levels
   // ********************

   // PWM idles high so the first period starts high; square wave
   // toggles at each wrap, giving half the wrap rate at the pin
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_in_prev_ff <= 1'b0;
         capture_prev_ff  <= 1'b1;
         pwm_level_ff     <= 1'b1;
         wave_level_ff    <= 1'b0;
      end else begin
         count_in_prev_ff <= count_input_pin;
         capture_prev_ff  <= pwm_capture_pin_i;
         pwm_level_ff     <= nxt_pwm_level;
         wave_level_ff    <= wave_level_ff ^ overflow; // see RULE8
      end
   end

   // ********************
   // Interrupt status, clear and enable
   // ********************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_evt
         // Set wins over a clear written in the same cycle
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               int_status_ff[gi] <= 1'b0;
            end else if (event_vec[gi]) begin
               int_status_ff[gi] <= 1'b1;
            end else if (wr_int_clr && reg_req.wdata[gi]) begin
               int_status_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         int_enable_ff <= '0;
      end else if (wr_int_en) begin
         int_enable_ff <= reg_req.wdata[NUM_EVENTS-1:0];
      end
   end

   // Master enable in control gates every timer interrupt
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= int_enable & |(int_status_ff & int_enable_ff);
      end
   end

   // ********************
   // Read path
   // ********************

   // Live control view merges the flags back at bits 7 and 6
   wire logic [15:0] control_view = control_ff |
      (16'(overflow_flag_ff) << BIT_OVERFLOW_FLAG) |
      (16'(external_flag_ff) << BIT_EXTERNAL_FLAG);

   // Unmapped and write-only addresses answer zero
   wire logic [15:0] read_mux =
      reg_hit(reg_req.addr, OFF_CONTROL)    ? control_view :
      reg_hit(reg_req.addr, OFF_COUNT)      ? 16'(count_value_ff) :
      reg_hit(reg_req.addr, OFF_RELOAD)     ? 16'(reload_capture_value_ff) :
      reg_hit(reg_req.addr, OFF_COMPARE)    ? 16'(compare_value_ff) :
      reg_hit(reg_req.addr, OFF_INT_STATUS) ? 16'(int_status_ff) :
      reg_hit(reg_req.addr, OFF_INT_ENABLE) ? 16'(int_enable_ff) :
                                              16'h0000;

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         read_data_ff <= 16'h0000;
      end else begin
         read_data_ff <= reg_req.rd ? read_mux : 16'h0000;
      end
   end

   // ********************
   // Outputs
   // ********************
   logic pwm_oe_n_ff;    // Capture pin drive enable, low drives
   logic wave_oe_n_ff;   // Waveform pin drive enable, low drives

   // Pins drive only in their modes; otherwise they are released
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pwm_oe_n_ff  <= 1'b1;
         wave_oe_n_ff <= 1'b1;
      end else begin
         pwm_oe_n_ff  <= ~pwm_mode;
         wave_oe_n_ff <= ~(wave_out_en & ~counter_sel); // see RULE14
      end
   end

   assign read_data            = read_data_ff;
   assign irq                  = irq_ff;
   assign pwm_capture_pin_o    = pwm_level_ff;
   assign pwm_capture_pin_oe_n = pwm_oe_n_ff;
   assign waveform_output_pin  = wave_level_ff;
   assign waveform_output_oe_n = wave_oe_n_ff;

endmodule : timer_pwm_unit

// [timer_pins_model.sv]
// Behavioural model of the pins facing the timer/PWM unit
`timescale 1ns/1ps
module timer_pins_model (
   input  wire logic clock,
   input  wire logic pin_drive,  // Unit's PWM drive level
   input  wire logic pin_oe_n,   // Low while the unit drives
   input  wire logic toggle,     // Request one count transition
   input  wire logic level,      // Level the far side puts on the pin
   output logic      count_pin,  // Count input seen by the unit
   output logic      pin_level   // Resolved capture/PWM wire
);
   initial count_pin = 1'b0;
   // One transition per request, so each request is exactly one count
   always @(posedge clock) if (toggle) count_pin <= !count_pin;
   // The unit owns the wire in PWM; else the far side sets direction
   assign pin_level = !pin_oe_n ? pin_drive : level;
endmodule : timer_pins_model

// [timer_pwm_unit_checker.sv]
// Port checker for the timer/PWM unit, bound to its top
`timescale 1ns/1ps
module timer_pwm_unit_checker
   import timer_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire reg_req_s    reg_req,
   input wire logic [15:0] read_data,
   input wire logic        pwm_capture_pin_oe_n,
   input wire logic        waveform_output_oe_n,
   input wire logic        irq
);
   logic [15:0] cfg_ff, cmp_ff, rel_ff, cnt_ff; // Last written values
   logic        rel_ok_ff, hold_ok_ff;          // Shadow still valid
   wire [3:0] adr    = reg_req.addr;
   wire       wr_ctl = reg_req.wr && adr == OFF_CONTROL;
   wire       wr_cnt = reg_req.wr && adr == OFF_COUNT;
   wire       wr_rel = reg_req.wr && adr == OFF_RELOAD;
   wire       rd_ctl = reg_req.rd && adr == OFF_CONTROL;
   wire       rd_cnt = reg_req.rd && adr == OFF_COUNT;
   wire       rd_rel = reg_req.rd && adr == OFF_RELOAD;
   wire       rd_cmp = reg_req.rd && adr == OFF_COMPARE;
   // Shadows of writes; capture mode spoils the reload copy until the next reload write
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         {cfg_ff, cmp_ff, rel_ff, cnt_ff} <= 64'h0;
         {rel_ok_ff, hold_ok_ff} <= 2'h2;
      end else begin
         if (wr_ctl) cfg_ff <= reg_req.wdata;
         if (reg_req.wr && adr == OFF_COMPARE) cmp_ff <= reg_req.wdata;
         if (wr_rel) rel_ff <= reg_req.wdata;
         if (wr_cnt) cnt_ff <= reg_req.wdata;
         rel_ok_ff  <= wr_rel | (rel_ok_ff & !(wr_ctl & reg_req.wdata[0]));
         hold_ok_ff <= (wr_cnt & ~|cfg_ff[3:2]) | (hold_ok_ff & !wr_ctl);
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   idle_read_zero_a:
      assert property (!$past(reg_req.rd) |-> read_data == 16'h0)
      else $error("read data not zero when idle");
   reserved_bits_a:
      assert property ($past(rd_ctl) |-> read_data[14:13] == 2'h0)
      else $error("control bits 14:13 not zero");
   compare_hold_a:
      assert property ($past(rd_cmp) |-> read_data == cmp_ff)
      else $error("compare value changed");
   reload_hold_a:
      assert property ($past(rd_rel) && rel_ok_ff |-> read_data == rel_ff)
      else $error("reload value changed outside capture");
   halt_hold_a:
      assert property ($past(rd_cnt) && hold_ok_ff |-> read_data == cnt_ff)
      else $error("halted count moved");
   pwm_drive_a:
      assert property ($stable(cfg_ff) |->
         pwm_capture_pin_oe_n == !(cfg_ff[11] | cfg_ff[12]))
      else $error("pin drive does not follow PWM mode");
   wave_drive_a:
      assert property ($stable(cfg_ff) |->
         waveform_output_oe_n == !(cfg_ff[5] & !cfg_ff[15]))
      else $error("waveform drive does not follow enable");
   irq_gated_a:
      assert property ($stable(cfg_ff) && !cfg_ff[1] |-> !irq)
      else $error("interrupt with timer interrupts off");
   cover property (!pwm_capture_pin_oe_n);
   cover property (irq);
   cover property ($past(rd_cnt) && hold_ok_ff);
endmodule : timer_pwm_unit_checker
bind timer_pwm_unit timer_pwm_unit_checker u_timer_pwm_unit_checker (
   .clock(clock), .reset_n(reset_n), .reg_req(reg_req),
   .read_data(read_data), .pwm_capture_pin_oe_n(pwm_capture_pin_oe_n),
   .waveform_output_oe_n(waveform_output_oe_n), .irq(irq));

// [enhanced_timer_pwm_unit_test.sv]
// Self-checking testbench for the timer/PWM unit
`timescale 1ns/1ps
module enhanced_timer_pwm_unit_test
   import timer_pkg::*;
;
   logic        clock, reset_n, tgl, drv, cnt_pin, pin_lvl, p;
   logic        pin_o, pin_oe_n, wave, wave_oe_n, irq;
   reg_req_s    req;                 // Register port request
   logic [15:0] read_data, d, c, r, cmp;
   int          err_count, n_tests, cycles, n;
   timer_pwm_unit u_timer_pwm_unit (.clock(clock), .reset_n(reset_n),
      .reg_req(req), .read_data(read_data), .count_input_pin(cnt_pin),
      .pwm_capture_pin_i(pin_lvl), .pwm_capture_pin_o(pin_o),
      .pwm_capture_pin_oe_n(pin_oe_n), .waveform_output_pin(wave),
      .waveform_output_oe_n(wave_oe_n), .irq(irq));
   timer_pins_model u_timer_pins_model (.clock(clock), .pin_drive(pin_o),
      .pin_oe_n(pin_oe_n), .toggle(tgl), .level(drv), .count_pin(cnt_pin),
      .pin_level(pin_lvl));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Hang guard, well above the longest sequence
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      {req.addr, req.wdata, req.wr} <= {a, v, 1'b1};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clock);
      {req.addr, req.rd} <= {a, 1'b1};
      @(posedge clock);
      req.rd <= 1'b0;
      #1 v = read_data;
   endtask : rd
   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      rd(a, d);
      chk(d, exp);
   endtask : rchk
   function automatic int div_of(int k);
      return (k < 6) ? 1 << (2 * k) : 1;
   endfunction : div_of
   // Clear mode: high below compare; the reload step returns high
   function automatic logic [15:0] pwm_exp(logic [15:0] cnt, logic set);
      logic [15:0] v;
      v = (cnt == 16'h03e8) ? 16'h0 : cnt + 16'h1;
      return 16'((v < cmp) ^ set);
   endfunction : pwm_exp
   initial begin
      {req, tgl, drv, reset_n} = '0;
      void'($urandom(32'h5eee556b));
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      rchk(OFF_CONTROL, 16'h0);
      rchk(4'hf, 16'h0);
      for (int i = 0; i < 4; i++) begin
         r = 16'($urandom()) & 16'hfffb;
         wr(OFF_CONTROL, r);
         rchk(OFF_CONTROL, r & 16'h9fff);
         r = 16'($urandom());
         wr(OFF_COUNT, r);
         repeat (8) @(posedge clock);
         rchk(OFF_COUNT, r);
      end
      wr(OFF_RELOAD, 16'hffff);
      for (int k = 0; k < 8; k++) begin
         wr(OFF_COUNT, 16'h0);
         wr(OFF_CONTROL, 16'h0004 | 16'(k << 8));
         rd(OFF_COUNT, c);
         repeat (4 * div_of(k) - 2) @(posedge clock);
         rchk(OFF_COUNT, c + 16'h4);
      end
      cmp = 16'($urandom_range(999, 1));
      wr(OFF_RELOAD, 16'h03e8);
      wr(OFF_COMPARE, cmp);
      for (int m = 0; m < 2; m++) begin
         wr(OFF_COUNT, 16'h0);
         wr(OFF_CONTROL, m ? 16'h1004 : 16'h0804);
         repeat (1100) @(posedge clock);
         for (int i = 0; i < 6; i++) begin
            repeat ($urandom_range(300)) @(posedge clock);
            rd(OFF_COUNT, c);
            chk(16'(pin_o), pwm_exp(c, m[0]));
         end
         rchk(OFF_CONTROL, (m ? 16'h1004 : 16'h0804) | 16'h0080);
         wr(OFF_CONTROL, 16'h0);
         rchk(OFF_CONTROL, 16'h0);
      end
      wr(OFF_COUNT, 16'h0);
      wr(OFF_CONTROL, 16'h1804);
      repeat (1100) @(posedge clock);
      #1 p = pin_o;
      repeat (1001) @(posedge clock);
      #1 chk(16'(pin_o), 16'(!p));
      wr(OFF_COMPARE, 16'h00ff);
      wr(OFF_RELOAD, 16'h0009);
      wr(OFF_INT_ENABLE, 16'h0002);
      wr(OFF_COUNT, 16'h0);
      wr(OFF_CONTROL, 16'h0024);
      wr(OFF_INT_CLEAR, 16'h0007);
      repeat (50) @(posedge clock);
      #1 p = wave;
      repeat (10) @(posedge clock);
      #1 chk(16'(wave), 16'(!p));
      wr(OFF_CONTROL, 16'h0002);
      rchk(OFF_INT_STATUS, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         wr(i == 3 ? OFF_INT_CLEAR : OFF_INT_ENABLE, 16'(i != 1));
         repeat (3) @(posedge clock);
         #1 chk(16'(irq), 16'(!i[0]));
      end
      for (int u = 0; u < 2; u++) begin
         @(posedge clock);
         drv <= u[0];
         wr(OFF_COUNT, 16'h0032);
         wr(OFF_CONTROL, 16'h8014);
         n = $urandom_range(40, 1);
         repeat (n) begin
            @(posedge clock);
            tgl <= 1'b1;
            @(posedge clock);
            tgl <= 1'b0;
         end
         repeat (3) @(posedge clock);
         rchk(OFF_COUNT, u ? 16'(50 + n) : 16'(50 - n));
         wr(OFF_CONTROL, 16'h0);
      end
      results();
   end
endmodule : enhanced_timer_pwm_unit_test
